//--- hdl/adc_conversion_control.sv
// Converter control: register slave, conversion sequencer and result formatting
`timescale 1ns/10ps
module adc_conversion_control (
  // Clock, reset and clock enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic [adc_conversion_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [adc_conversion_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device events
  input wire logic sleep_active,
  input wire logic event_trigger,
  output logic timer_clear,
  output logic conversion_done_flag,
  output logic wake_request,
  // Analog core
  output adc_conversion_pkg::analog_ctrl_t analog_ctrl,
  output logic [adc_conversion_pkg::RES_W-1:0] trial_code,
  input wire logic compare_high
);
  import adc_conversion_pkg::*;

  typedef struct packed {
    conv_state_t state;
    logic converter_enable;
    logic result_justify_select;
    logic positive_reference_select;
    logic [2:0] input_channel_select;
    logic conversion_irq_enable;
    logic flag;
    logic osc_select;
    logic [2:0] div_select;
    logic [DIV_W-1:0] div_count;
    logic [3:0] period_count;
    logic [RES_W-1:0] result_value;
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic timer_clear;
    logic wake;
    analog_ctrl_t analog;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;

  logic [DIV_W-1:0] period_limit;
  logic period_tick;
  logic busy;
  logic do_write;
  logic wr_control;
  logic wr_status;
  logic wr_clock;
  logic start_req;
  logic abort_req;
  logic sleep_abort;
  logic sar_load;
  logic sar_step;
  logic [RES_W-1:0] sar_value;
  logic [7:0] read_byte;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    return (addr == ADDR_CONTROL) || (addr == ADDR_RESULT_HIGH) || (addr == ADDR_RESULT_LOW)
      || (addr == ADDR_STATUS) || (addr == ADDR_CLOCK_CFG);
  endfunction : is_mapped

  // Conversion clock as an enable tick; one domain, so no start or done event can slip
  assign period_limit = s.osc_select ? OSC_LAST : ((DIV_BASE << s.div_select) - DIV_ONE);
  assign period_tick = (s.div_count == period_limit);
  assign busy = (s.state == ST_DELAY) || (s.state == ST_CONVERT) || (s.state == ST_FINISH);

  // Write is performed once address and data are both held and byte strobe 0 is set
  assign do_write = s.aw_held && s.w_held && s.wstrb0;
  assign wr_control = do_write && (s.awaddr == ADDR_CONTROL);
  assign wr_status = do_write && (s.awaddr == ADDR_STATUS);
  assign wr_clock = do_write && (s.awaddr == ADDR_CLOCK_CFG);

  // Start only counts when the module was already on before this write
  assign start_req = (wr_control && s.wdata[BIT_GO] && s.wdata[BIT_ENABLE] && s.converter_enable)
    || (event_trigger && s.converter_enable);
  assign abort_req = wr_control && !s.wdata[BIT_GO]
    && ((s.state == ST_DELAY) || (s.state == ST_CONVERT));
  // Divided clock stops in sleep, so anything running short of ST_FINISH is lost
  assign sleep_abort = sleep_active && !s.osc_select
    && (s.state != ST_OFF) && (s.state != ST_PARKED);

  // Register read view
  always_comb begin
    read_byte = 8'h00;
    case (s_axi_araddr)
      ADDR_CONTROL: begin
        read_byte[BIT_ENABLE] = s.converter_enable;
        read_byte[BIT_GO] = busy;
        read_byte[CHAN_MSB:CHAN_LSB] = s.input_channel_select;
        read_byte[BIT_REF] = s.positive_reference_select;
        read_byte[BIT_JUSTIFY] = s.result_justify_select;
      end
      ADDR_RESULT_HIGH: begin
        if (s.result_justify_select) begin
          read_byte = {6'h00, s.result_value[9:8]};
        end else begin
          read_byte = s.result_value[9:2];
        end
      end
      ADDR_RESULT_LOW: begin
        if (s.result_justify_select) begin
          read_byte = s.result_value[7:0];
        end else begin
          read_byte = {s.result_value[1:0], 6'h00};
        end
      end
      ADDR_STATUS: begin
        read_byte[BIT_FLAG] = s.flag;
        read_byte[BIT_IRQ_EN] = s.conversion_irq_enable;
        read_byte[BIT_POWERED] = s.analog.powered;
      end
      ADDR_CLOCK_CFG: begin
        read_byte[DIV_MSB:DIV_LSB] = s.div_select;
        read_byte[BIT_OSC] = s.osc_select;
      end
      default: begin
        read_byte = 8'h00;
      end
    endcase
  end

  always_comb begin
    next_s = s;
    sar_load = 1'b0;
    sar_step = 1'b0;
    next_s.timer_clear = event_trigger;

    // Free running period divider, realigned at each start
    if (period_tick) begin
      next_s.div_count = '0;
    end else begin
      next_s.div_count = s.div_count + DIV_ONE;
    end

    // Bus channels
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata[7:0];
      next_s.wstrb0 = s_axi_wstrb[0];
    end
    if (s.aw_held && s.w_held) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = is_mapped(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = read_byte;
      next_s.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end

    // Register writes; result addresses take no write
    if (wr_control) begin
      next_s.converter_enable = s.wdata[BIT_ENABLE];
      next_s.input_channel_select = s.wdata[CHAN_MSB:CHAN_LSB];
      next_s.positive_reference_select = s.wdata[BIT_REF];
      next_s.result_justify_select = s.wdata[BIT_JUSTIFY];
    end
    if (wr_status) begin
      next_s.conversion_irq_enable = s.wdata[BIT_IRQ_EN];
      if (s.wdata[BIT_FLAG]) begin
        next_s.flag = 1'b0;
      end
    end
    if (wr_clock) begin
      next_s.osc_select = s.wdata[BIT_OSC];
      if (s.wdata[DIV_MSB:DIV_LSB] > DIV_SEL_MAX) begin
        next_s.div_select = DIV_SEL_MAX;
      end else begin
        next_s.div_select = s.wdata[DIV_MSB:DIV_LSB];
      end
    end

    // Conversion sequencer
    case (s.state)
      ST_OFF: begin
        if (s.converter_enable) begin
          next_s.state = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        if (start_req) begin
          next_s.div_count = '0;
          next_s.period_count = '0;
          if (s.osc_select) begin
            next_s.state = ST_DELAY;
          end else begin
            next_s.state = ST_CONVERT;
            sar_load = 1'b1;
          end
        end
      end
      ST_DELAY: begin
        // One instruction of grace so sleep can run before the conversion
        if (s.div_count == INSTR_LAST) begin
          next_s.state = ST_CONVERT;
          next_s.div_count = '0;
          sar_load = 1'b1;
        end
      end
      ST_CONVERT: begin
        // First period holds the sample, then one bit per period
        if (period_tick) begin
          if (s.period_count != '0) begin
            sar_step = 1'b1;
          end
          if (s.period_count == CONV_LAST) begin
            next_s.state = ST_FINISH;
          end else begin
            next_s.period_count = s.period_count + COUNT_ONE;
          end
        end
      end
      ST_FINISH: begin
        next_s.result_value = sar_value;
        next_s.flag = 1'b1;
        if (sleep_active && !s.conversion_irq_enable) begin
          next_s.state = ST_PARKED;
        end else begin
          next_s.state = ST_ACQUIRE;
        end
      end
      ST_ABORT: begin
        if (period_tick) begin
          if (s.period_count == ABORT_LAST) begin
            next_s.state = ST_ACQUIRE;
          end else begin
            next_s.period_count = s.period_count + COUNT_ONE;
          end
        end
      end
      ST_PARKED: begin
        // Powered down with the enable bit left set until sleep ends
        if (!sleep_active) begin
          next_s.state = ST_ACQUIRE;
        end
      end
      default: begin
        next_s.state = ST_OFF;
      end
    endcase

    // Abort leaves the old result untouched and waits before reacquiring
    if (abort_req) begin
      next_s.state = ST_ABORT;
      next_s.period_count = '0;
      next_s.div_count = '0;
    end
    if (sleep_abort) begin
      next_s.state = ST_PARKED;
    end
    if (!next_s.converter_enable) begin
      next_s.state = ST_OFF;
    end

    // Wake needs an enabled interrupt; the flag itself is set regardless
    next_s.wake = sleep_active && next_s.flag && next_s.conversion_irq_enable;

    // Analog core controls follow the next state so they leave a flop
    next_s.analog.powered = next_s.converter_enable
      && (next_s.state != ST_OFF) && (next_s.state != ST_PARKED);
    next_s.analog.sampling = (next_s.state == ST_ACQUIRE);
    next_s.analog.channel = next_s.input_channel_select;
    next_s.analog.ref_external = next_s.positive_reference_select;
  end

  // Results are cleared too, though software must not rely on them before a conversion
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  sar_register u_sar (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .load(sar_load),
    .step(sar_step),
    .compare_high(compare_high),
    .trial(trial_code),
    .value(sar_value)
  );

  // Ready falls with the clock enable so no beat is taken while frozen
  assign s_axi_awready = ce && !s.aw_held && !s.bvalid;
  assign s_axi_wready = ce && !s.w_held && !s.bvalid;
  assign s_axi_arready = ce && !s.rvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = {24'h000000, s.rdata};
  assign timer_clear = s.timer_clear;
  assign conversion_done_flag = s.flag;
  assign wake_request = s.wake;
  assign analog_ctrl = s.analog;
endmodule : adc_conversion_control

//--- hdl/adc_conversion_pkg.sv
// Constants and types shared by the converter control block
package adc_conversion_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int INSTR_CYCLE_NS = 200;
  localparam int INSTR_CYCLES = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_PERIOD_NS = 4000;
  localparam int OSC_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CONV_PERIODS = 11;
  localparam int ABORT_PERIODS = 2;
  localparam int RES_W = 10;
  localparam int DIV_W = 8;
  localparam int ADDR_W = 8;

  localparam logic [DIV_W-1:0] INSTR_LAST = DIV_W'(INSTR_CYCLES - 1);
  localparam logic [DIV_W-1:0] OSC_LAST = DIV_W'(OSC_CYCLES - 1);
  localparam logic [DIV_W-1:0] DIV_BASE = 8'h02;
  localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
  localparam logic [3:0] CONV_LAST = 4'(CONV_PERIODS - 1);
  localparam logic [3:0] ABORT_LAST = 4'(ABORT_PERIODS - 1);
  localparam logic [3:0] COUNT_ONE = 4'h1;
  localparam logic [2:0] DIV_SEL_MAX = 3'h5;

  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_LOW = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_CFG = 8'h10;

  localparam int BIT_ENABLE = 0;
  localparam int BIT_GO = 1;
  localparam int CHAN_LSB = 2;
  localparam int CHAN_MSB = 4;
  localparam int BIT_REF = 6;
  localparam int BIT_JUSTIFY = 7;
  localparam int BIT_FLAG = 0;
  localparam int BIT_IRQ_EN = 1;
  localparam int BIT_POWERED = 2;
  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 2;
  localparam int BIT_OSC = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF, ST_ACQUIRE, ST_DELAY, ST_CONVERT, ST_FINISH, ST_ABORT, ST_PARKED
  } conv_state_t;

  typedef struct packed {
    logic powered;
    logic sampling;
    logic [2:0] channel;
    logic ref_external;
  } analog_ctrl_t;

  typedef struct packed {
    logic [RES_W-1:0] probe;
    logic [RES_W-1:0] value;
  } sar_state_t;
endpackage : adc_conversion_pkg

//--- hdl/sar_register.sv
// Successive approximation register, one decision per step, most significant first
`timescale 1ns/10ps
module sar_register (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic load,
  input wire logic step,
  input wire logic compare_high,
  // Trial code and settled value
  output logic [adc_conversion_pkg::RES_W-1:0] trial,
  output logic [adc_conversion_pkg::RES_W-1:0] value
);
  import adc_conversion_pkg::*;

  sar_state_t s;
  sar_state_t next_s;
  logic [RES_W-1:0] decided;

  // Each bit keeps its trial one only while it is the bit under test
  for (genvar i = 0; i < RES_W; i++) begin : g_bit
    assign decided[i] = s.probe[i] ? compare_high : s.value[i];
  end

  always_comb begin
    next_s = s;
    if (load) begin
      next_s.probe = {1'b1, {(RES_W-1){1'b0}}};
      next_s.value = '0;
    end else if (step) begin
      next_s.value = decided;
      next_s.probe = s.probe >> 1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign trial = s.value | s.probe;
  assign value = s.value;
endmodule : sar_register

//--- sim/analog_core_model.sv
// Behavioural analog core: one target code per channel and reference, compared against the trial code
`timescale 1ns/10ps
module analog_core_model (
  // Clock
  input wire logic clock,
  // From the converter
  input wire adc_conversion_pkg::analog_ctrl_t analog_ctrl,
  input wire logic [adc_conversion_pkg::RES_W-1:0] trial_code,
  // Comparator
  output logic compare_high
);
  import adc_conversion_pkg::*;
  logic [RES_W-1:0] target;
  logic junk = 1'b0;
  assign target = (10'h155 + 10'(analog_ctrl.channel) * 10'h47) ^ {analog_ctrl.ref_external, 9'h000};
  // An unpowered core toggles, so a result taken while off cannot match by luck
  always @(posedge clock) junk <= ~junk;
  assign compare_high = analog_ctrl.powered ? (target >= trial_code) : junk;
endmodule : analog_core_model

//--- sim/adc_conversion_control_checker.sv
// Port checker for the converter control block
`timescale 1ns/10ps
module adc_conversion_control_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Events and core
  input wire logic sleep_active,
  input wire logic event_trigger,
  input wire logic timer_clear,
  input wire logic conversion_done_flag,
  input wire logic wake_request,
  input wire adc_conversion_pkg::analog_ctrl_t analog_ctrl
);
  import adc_conversion_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  property p_trigger_clear;
    ce |=> timer_clear == $past(event_trigger);
  endproperty
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_read_refused;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_write_refused;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  // Wake lags sleep by one edge but shows the flag of its own cycle
  property p_wake_cause;
    wake_request && $past(ce) |-> conversion_done_flag && $past(sleep_active);
  endproperty
  // Only a register write, landing with the response, may drop the flag
  property p_flag_sticky;
    conversion_done_flag |=> conversion_done_flag || $rose(s_axi_bvalid);
  endproperty
  property p_flag_powered;
    $rose(conversion_done_flag) |-> $past(analog_ctrl.powered);
  endproperty
  property p_reset_off;
    $fell(rst) |-> !conversion_done_flag && !analog_ctrl.powered && !s_axi_bvalid;
  endproperty
  a_trigger_clear: assert property (p_trigger_clear) else $error("timer clear not one edge after trigger");
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer dropped early");
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped early");
  a_read_refused: assert property (p_read_refused) else $error("read taken while answer pending");
  a_write_refused: assert property (p_write_refused) else $error("write taken while answer pending");
  a_wake_cause: assert property (p_wake_cause) else $error("wake without sleep and flag");
  a_flag_sticky: assert property (p_flag_sticky) else $error("done flag cleared by hardware");
  a_flag_powered: assert property (p_flag_powered) else $error("done flag while unpowered");
  a_reset_off: assert property (p_reset_off) else $error("state not off after reset");
  c_done: cover property ($rose(conversion_done_flag));
  c_wake: cover property ($rose(wake_request));
  c_trigger: cover property (event_trigger ##1 timer_clear);
endmodule : adc_conversion_control_checker

bind adc_conversion_control adc_conversion_control_checker checker_i (.clock, .rst, .ce, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .sleep_active, .event_trigger, .timer_clear, .conversion_done_flag, .wake_request, .analog_ctrl);

//--- sim/adc_conversion_control_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module adc_conversion_control_bench;
  import adc_conversion_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic sleep_active = 1'b0;
  logic event_trigger = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic timer_clear, conversion_done_flag, wake_request, compare_high;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [9:0] trial_code;
  analog_ctrl_t analog_ctrl;
  int miscompares = 0;
  int compares = 0;

  adc_conversion_control uut (.clock, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_active,
    .event_trigger, .timer_clear, .conversion_done_flag, .wake_request, .analog_ctrl, .trial_code, .compare_high);
  analog_core_model core (.clock, .analog_ctrl, .trial_code, .compare_high);

  always #10 clock = ~clock;

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic hang(input string what);
    chk(what, 32'h0, 32'h1);
    test_done();
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    hang("write timeout");
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hang("read timeout");
  endtask : rdr

  task automatic wait_idle();
    for (int i = 0; i < 1000; i++) begin
      rdr(ADDR_CONTROL);
      if (rd[BIT_GO] === 1'b0) return;
    end
    hang("conversion timeout");
  endtask : wait_idle

  task automatic check_result(input logic [7:0] ctl);
    logic [9:0] c;
    c = (10'h155 + 10'(ctl[4:2]) * 10'h47) ^ {ctl[6], 9'h000};
    rdr(ADDR_RESULT_HIGH);
    chk("result high", rd, ctl[7] ? {30'h0, c[9:8]} : {24'h0, c[9:2]});
    rdr(ADDR_RESULT_LOW);
    chk("result low", rd, ctl[7] ? {24'h0, c[7:0]} : {24'h0, c[1:0], 6'h00});
  endtask : check_result

  // Enable in one write, start in the next
  task automatic conv(input logic [7:0] ctl);
    wr(ADDR_CONTROL, ctl | 8'h01);
    wr(ADDR_CONTROL, ctl | 8'h03);
    rdr(ADDR_CONTROL);
    chk("go busy", 32'(rd[BIT_GO]), 32'h1);
    wait_idle();
  endtask : conv

  task automatic t_registers();
    rdr(ADDR_CONTROL);
    chk("control reset", rd, 32'h0);
    wr(ADDR_CONTROL, 8'hfc);
    rdr(ADDR_CONTROL);
    chk("control fields", rd, 32'hdc);
    s_axi_wstrb <= 4'h0;
    wr(ADDR_CONTROL, 8'h00);
    s_axi_wstrb <= 4'h1;
    rdr(ADDR_CONTROL);
    chk("masked write", rd, 32'hdc);
    wr(ADDR_CLOCK_CFG, 8'h0f);
    rdr(ADDR_CLOCK_CFG);
    chk("clock select clamp", rd, 32'h0d);
    wr(ADDR_RESULT_LOW, 8'hff);
    chk("result write resp", 32'(rsp), 32'(RESP_OKAY));
    rdr(ADDR_RESULT_LOW);
    chk("result read only", rd, 32'h0);
    wr(8'h14, 8'h01);
    chk("unmapped write", 32'(rsp), 32'(RESP_SLVERR));
    rdr(8'h14);
    chk("unmapped read", {rd[29:0], rsp}, {30'h0, RESP_SLVERR});
    $display("registers test done");
  endtask : t_registers

  task automatic t_channels();
    logic [7:0] ctl;
    wr(ADDR_CLOCK_CFG, 8'h00);
    for (int ch = 0; ch < 7; ch++) begin
      ctl = {ch[0], ch[1], 1'b0, ch[2:0], 2'b00};
      wr(ADDR_STATUS, 8'h01);
      conv(ctl);
      chk("channel pins", 32'(analog_ctrl.channel), 32'(ch));
      chk("reference pin", 32'(analog_ctrl.ref_external), 32'(ctl[6]));
      rdr(ADDR_STATUS);
      chk("done flag", 32'(rd[BIT_FLAG]), 32'h1);
      check_result(ctl);
    end
    $display("channels test done");
  endtask : t_channels

  task automatic t_timing_abort();
    int n;
    wr(ADDR_CLOCK_CFG, 8'h05);
    wr(ADDR_STATUS, 8'h01);
    wr(ADDR_CONTROL, 8'h01);
    wr(ADDR_CONTROL, 8'h03);
    n = 0;
    while (conversion_done_flag !== 1'b1 && n < 1000) begin
      @(posedge clock);
      n++;
    end
    chk("conversion length", 32'(n >= 700 && n <= 765), 32'h1);
    wr(ADDR_STATUS, 8'h01);
    wr(ADDR_CONTROL, 8'h0f);
    repeat (200) @(posedge clock);
    wr(ADDR_CONTROL, 8'h0d);
    wr(ADDR_CONTROL, 8'h0f);
    rdr(ADDR_CONTROL);
    chk("go during wait", 32'(rd[BIT_GO]), 32'h0);
    chk("sampling in wait", 32'(analog_ctrl.sampling), 32'h0);
    rdr(ADDR_STATUS);
    chk("flag after abort", 32'(rd[BIT_FLAG]), 32'h0);
    check_result(8'h01);
    repeat (140) @(posedge clock);
    chk("sampling after wait", 32'(analog_ctrl.sampling), 32'h1);
    conv(8'h0c);
    check_result(8'h0c);
    $display("timing and abort test done");
  endtask : t_timing_abort

  task automatic t_trigger();
    wr(ADDR_CLOCK_CFG, 8'h00);
    wr(ADDR_STATUS, 8'h01);
    @(posedge clock);
    event_trigger <= 1'b1;
    @(posedge clock);
    event_trigger <= 1'b0;
    @(negedge clock);
    chk("timer clear", 32'(timer_clear), 32'h1);
    rdr(ADDR_CONTROL);
    chk("trigger go", 32'(rd[BIT_GO]), 32'h1);
    wait_idle();
    rdr(ADDR_STATUS);
    chk("trigger flag", 32'(rd[BIT_FLAG]), 32'h1);
    $display("trigger test done");
  endtask : t_trigger

  // A low clock enable must stall the conversion, not lose or finish it
  task automatic t_freeze();
    wr(ADDR_STATUS, 8'h01);
    wr(ADDR_CONTROL, 8'h03);
    ce <= 1'b0;
    repeat (60) @(posedge clock);
    chk("frozen flag", 32'(conversion_done_flag), 32'h0);
    ce <= 1'b1;
    wait_idle();
    chk("flag after freeze", 32'(conversion_done_flag), 32'h1);
    $display("freeze test done");
  endtask : t_freeze

  // Oscillator clock keeps converting in sleep; divided clock parks
  task automatic t_sleep(input logic [7:0] cfg, input logic [7:0] stat);
    wr(ADDR_CLOCK_CFG, cfg);
    wr(ADDR_STATUS, stat);
    wr(ADDR_CONTROL, 8'h93);
    sleep_active <= 1'b1;
    for (int i = 0; i < 3000 && conversion_done_flag !== 1'b1 && cfg[BIT_OSC]; i++) @(posedge clock);
    repeat (4) @(posedge clock);
    chk("wake", 32'(wake_request), 32'(stat[BIT_IRQ_EN]));
    chk("powered", 32'(analog_ctrl.powered), 32'(stat[BIT_IRQ_EN]));
    chk("sleep flag", 32'(conversion_done_flag), 32'(cfg[BIT_OSC]));
    rdr(ADDR_CONTROL);
    chk("enable kept", rd, 32'h91);
    rdr(ADDR_STATUS);
    chk("status view", rd, 32'({stat[BIT_IRQ_EN], stat[BIT_IRQ_EN], cfg[BIT_OSC]}));
    if (cfg[BIT_OSC]) check_result(8'h90);
    sleep_active <= 1'b0;
    wait_idle();
    $display("sleep test done");
  endtask : t_sleep

  task automatic t_reset();
    wr(ADDR_CLOCK_CFG, 8'h05);
    wr(ADDR_CONTROL, 8'h03);
    repeat (50) @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    chk("powered after reset", 32'(analog_ctrl.powered), 32'h0);
    rdr(ADDR_CONTROL);
    chk("control after reset", rd, 32'h0);
    $display("reset test done");
  endtask : t_reset

  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_registers();
    t_channels();
    t_timing_abort();
    t_trigger();
    t_freeze();
    t_sleep(8'h08, 8'h03);
    t_sleep(8'h08, 8'h01);
    t_sleep(8'h05, 8'h01);
    t_reset();
    test_done();
  end
endmodule : adc_conversion_control_bench
